/* logic/projector_power_sequencer.sv */
// Power-up and power-down sequencer of the display controller.
`timescale 1ns/100ps
module projector_power_sequencer #(
    parameter int BOOT_CYCLES = pseq_pkg::BOOT_CYC,
    parameter int PLL_CYCLES = pseq_pkg::PLL_CYC,
    parameter int SETUP_CYCLES = pseq_pkg::SETUP_CYC,
    parameter int PARK_CYCLES = pseq_pkg::PARK_CYC,
    parameter int REG_STOP_CYCLES = pseq_pkg::REG_STOP_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic power_on_hold_n_i,
    input wire logic fast_park_warning_n_i,
    input wire logic projector_on_request_i,
    input wire logic companion_ready_i,
    input wire logic core_power_good_i,
    output logic init_busy_o,
    output logic init_busy_oe_o,
    output logic command_ready_o,
    output logic pll_lock_req_o,
    output logic flash_load_o,
    output logic companion_write_o,
    output logic display_enable_o,
    output logic park_active_o,
    output logic fast_park_o,
    output logic reset_reg_enable_o,
    output logic low_power_off_o
);
    import pseq_pkg::*;

    typedef struct packed {
        seq_state_e st;
        logic hold_d;
        logic busy;
        logic busy_oe;
        logic cmd_rdy;
        logic pll;
        logic flash;
        logic cwr;
        logic disp;
        logic park;
        logic fpark;
        logic regen;
        logic off;
    } seq_s;

    seq_s s_r;
    seq_s s_nxt;
    seq_timer_if tif ();

    seq_timer u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .t(tif)
    );

    logic boot_hold_done;
    logic [TW-1:0] boot_cnt_r;

    always_comb begin
        s_nxt = s_r;
        tif.load = 1'b0;
        tif.count = '0;
        s_nxt.hold_d = power_on_hold_n_i;
        case (s_r.st)
            ST_IDLE: begin
                if (power_on_hold_n_i && !s_r.hold_d) begin // [R3]
                    s_nxt.st = ST_PLL; // [R21]
                    s_nxt.busy = 1'b1; // [R18]
                    tif.load = 1'b1;
                    tif.count = TW'(PLL_CYCLES);
                end
            end
            ST_PLL: begin
                if (tif.done) begin
                    s_nxt.st = ST_LOAD; // [R21] [R17]
                    tif.load = 1'b1;
                    tif.count = TW'(BOOT_CYCLES - PLL_CYCLES); // [R5]
                end
            end
            ST_LOAD: begin
                if (tif.done) begin
                    s_nxt.st = ST_WAIT_RDY;
                end
            end
            ST_WAIT_RDY: begin
                if (companion_ready_i) begin // [R16]
                    s_nxt.st = ST_SETUP; // [R15]
                    tif.load = 1'b1;
                    tif.count = TW'(SETUP_CYCLES);
                end
            end
            ST_SETUP: begin
                if (tif.done) begin
                    s_nxt.st = ST_READY;
                    s_nxt.busy = 1'b0; // [R4]
                end
            end
            ST_READY, ST_ON: begin
                if (!fast_park_warning_n_i) begin // [R13]
                    s_nxt.st = ST_FAST_PARK;
                    tif.load = 1'b1;
                    tif.count = TW'(FAST_PARK_CYC);
                end else if (projector_on_request_i) begin
                    s_nxt.st = ST_ON; // [R1]
                end else if (s_r.st == ST_ON) begin
                    s_nxt.st = ST_PARK; // [R2]
                    tif.load = 1'b1;
                    tif.count = TW'(PARK_CYCLES - 1); // [R9]
                end
            end
            ST_PARK: begin
                if (!fast_park_warning_n_i) begin // [R13]
                    s_nxt.st = ST_FAST_PARK;
                    tif.load = 1'b1;
                    tif.count = TW'(FAST_PARK_CYC);
                end else if (tif.done) begin
                    s_nxt.st = ST_REG_HOLD;
                    tif.load = 1'b1;
                    tif.count = TW'(REG_STOP_CYCLES); // [R12]
                end
            end
            ST_REG_HOLD, ST_FAST_PARK: begin
                if (tif.done) begin
                    s_nxt.st = ST_OFF;
                end
            end
            ST_OFF: begin
                if (projector_on_request_i && fast_park_warning_n_i) begin
                    s_nxt.st = ST_READY;
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
        if (!power_on_hold_n_i) begin // [R22]
            s_nxt.st = ST_IDLE;
            s_nxt.busy = 1'b0;
            tif.load = 1'b1;
            tif.count = '0;
        end
        s_nxt.busy_oe = core_power_good_i && s_nxt.st != ST_IDLE; // [R14]
        s_nxt.cmd_rdy = s_nxt.st inside {ST_READY, ST_ON}; // [R4] [R15]
        s_nxt.pll = s_nxt.st != ST_IDLE;
        s_nxt.flash = s_nxt.st == ST_LOAD; // [R17]
        s_nxt.cwr = s_nxt.st == ST_SETUP; // [R15]
        s_nxt.disp = s_nxt.st == ST_ON; // [R1]
        s_nxt.park = s_nxt.st == ST_PARK;
        s_nxt.fpark = s_nxt.st == ST_FAST_PARK; // [R13]
        s_nxt.regen = s_nxt.st inside {ST_READY, ST_ON, ST_PARK, ST_REG_HOLD}; // [R12]
        s_nxt.off = s_nxt.st == ST_OFF; // [R2]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign init_busy_o = s_r.busy;
    assign init_busy_oe_o = s_r.busy_oe;
    assign command_ready_o = s_r.cmd_rdy;
    assign pll_lock_req_o = s_r.pll;
    assign flash_load_o = s_r.flash;
    assign companion_write_o = s_r.cwr;
    assign display_enable_o = s_r.disp;
    assign park_active_o = s_r.park;
    assign fast_park_o = s_r.fpark;
    assign reset_reg_enable_o = s_r.regen;
    assign low_power_off_o = s_r.off;

    // Counts cycles in the park state to bound its length.
    always_ff @(posedge clk_i) begin
        if (rst_i || s_r.st != ST_PARK) begin
            boot_cnt_r <= '0;
        end else begin
            boot_cnt_r <= boot_cnt_r + 1'b1;
        end
    end
    assign boot_hold_done = boot_cnt_r <= TW'(PARK_CYCLES);

    a_hold_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [R22]
        !power_on_hold_n_i |=> s_r.st == ST_IDLE && !init_busy_o)
        else $error("sequencer not idle while hold low");
    a_busy_rise: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
        power_on_hold_n_i && $past(power_on_hold_n_i) == 1'b0 && s_r.st == ST_IDLE
        |=> init_busy_o)
        else $error("busy not raised after hold release");
    a_busy_done: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
        $fell(init_busy_o) && power_on_hold_n_i |-> command_ready_o)
        else $error("busy fell without command ready");
    a_cmd_gated: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
        command_ready_o |-> !init_busy_o && s_r.st != ST_SETUP)
        else $error("commands accepted before setup");
    a_fast_park: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
        s_r.st inside {ST_READY, ST_ON, ST_PARK} && !fast_park_warning_n_i
        && power_on_hold_n_i |=> fast_park_o)
        else $error("fast park not started");
    a_park_start: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
        s_r.st == ST_ON && !projector_on_request_i && fast_park_warning_n_i
        && power_on_hold_n_i |=> park_active_o && !display_enable_o)
        else $error("park not started");
    a_park_bound: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
        boot_hold_done)
        else $error("park exceeded bound");
    a_disp_on: assert property (@(posedge clk_i) disable iff (rst_i) // [R1]
        s_r.st == ST_READY && projector_on_request_i && fast_park_warning_n_i
        && power_on_hold_n_i |=> display_enable_o)
        else $error("display not enabled");
    a_pll_first: assert property (@(posedge clk_i) disable iff (rst_i) // [R21]
        flash_load_o |-> $past(s_r.st) inside {ST_PLL, ST_LOAD})
        else $error("flash load before pll");
    a_reg_stop: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
        $fell(park_active_o) && !fast_park_o && $past(power_on_hold_n_i)
        |-> reset_reg_enable_o)
        else $error("regulation stopped early");
    a_oe_core: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
        !core_power_good_i |=> !init_busy_oe_o)
        else $error("output driven without core power");
    c_boot: cover property (@(posedge clk_i) $fell(init_busy_o));
    c_on: cover property (@(posedge clk_i) $rose(display_enable_o));
    c_park: cover property (@(posedge clk_i) $rose(low_power_off_o));
    c_fpark: cover property (@(posedge clk_i) $rose(fast_park_o));
endmodule // projector_power_sequencer

/* logic/pseq_pkg.sv */
// Package of constants and types for the projector power sequencer.
// Overview of operation
// R1: Projector request high powers display path, images.
// R2: Request low shuts chipset to off state.
// R3: Power-on hold rising edge starts initialization.
// R4: Init done drives busy low, commands accepted.
// R5: Boot lasts about 100 ms typically.
// R6: Monitor raises park warning before hold release.
// R7: Monitor holds hold low 5 ms after supplies.
// R8: Reference clock stable; release follows within 1 ms.
// R9: Park completes within 20 ms of request fall.
// R10: System keeps supplies 20 ms after request fall.
// R11: Keep main supply 50 ms after request fall.
// R12: Reset regulation stops 12 ms after normal park.
// R13: Park warning low starts fast park.
// R14: Core power lost tristates host-supply outputs.
// R15: Companion ready triggers 2.75 ms register setup.
// R16: Companion ready may take 1.5 s.
// R17: Firmware loads from flash, kept during operation.
// R18: Busy line high right after hold release.
// R19: Host keeps request until busy goes low.
// R20: Clock and hold stay 32 us after warning.
// R21: Initialization locks PLL then loads flash data.
// R22: Hold low keeps idle, timers cleared, sync.
package pseq_pkg;
    localparam int CLK_MHZ = 100;
    localparam int BOOT_MS = 100;
    localparam int PLL_LOCK_US = 100;
    localparam int SETUP_US = 2750;
    localparam int PARK_MS = 20;
    localparam int FAST_PARK_US = 32;
    localparam int REG_STOP_MS = 12;
    localparam int BOOT_CYC = BOOT_MS * 1000 * CLK_MHZ;
    localparam int PLL_CYC = PLL_LOCK_US * CLK_MHZ;
    localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
    localparam int PARK_CYC = PARK_MS * 1000 * CLK_MHZ;
    localparam int FAST_PARK_CYC = FAST_PARK_US * CLK_MHZ;
    localparam int REG_STOP_CYC = REG_STOP_MS * 1000 * CLK_MHZ;
    localparam int TW = 24;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_PLL = 4'b0001,
        ST_LOAD = 4'b0010,
        ST_WAIT_RDY = 4'b0011,
        ST_SETUP = 4'b0100,
        ST_READY = 4'b0101,
        ST_ON = 4'b0110,
        ST_PARK = 4'b0111,
        ST_REG_HOLD = 4'b1000,
        ST_FAST_PARK = 4'b1001,
        ST_OFF = 4'b1010
    } seq_state_e;
endpackage

/* logic/seq_timer_if.sv */
// Interface between the sequencer and its interval timer.
`timescale 1ns/100ps
interface seq_timer_if;
    logic load;
    logic [pseq_pkg::TW-1:0] count;
    logic done;
    modport ctrl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface

/* logic/seq_timer.sv */
// Down counter that flags the end of a loaded interval.
`timescale 1ns/100ps
module seq_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    seq_timer_if.tmr t
);
    import pseq_pkg::*;
    typedef struct packed {
        logic [TW-1:0] cnt;
        logic done;
    } tmr_s;
    tmr_s st_r;
    tmr_s st_nxt;
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (t.load) begin
            st_nxt.cnt = t.count;
        end else if (st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - 1'b1;
            st_nxt.done = (st_r.cnt == {{(TW-1){1'b0}}, 1'b1});
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign t.done = st_r.done;
endmodule // seq_timer

/* sim/pseq_partner.sv */
// Power monitor and host model driving the sequencer inputs.
`timescale 1ns/100ps
module pseq_partner (
    input wire logic clk_i,
    output logic hold_n_o,
    output logic warn_n_o,
    output logic req_o,
    output logic comp_rdy_o,
    output logic core_good_o
);
    initial begin
        hold_n_o = 1'b0;
        warn_n_o = 1'b0;
        req_o = 1'b0;
        comp_rdy_o = 1'b0;
        core_good_o = 1'b1;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Warning is raised first and hold stays low several cycles before release.
    task automatic release_hold(input logic [3:0] r);
        hold_n_o = 1'b0;
        req_o = r[0];
        comp_rdy_o = r[1];
        warn_n_o = r[2];
        core_good_o = r[3];
        step(1);
        req_o = 1'b0;
        comp_rdy_o = 1'b0;
        core_good_o = 1'b1;
        warn_n_o = 1'b1;
        step(6);
        hold_n_o = 1'b1;
    endtask
    task automatic hold_low();
        hold_n_o = 1'b0;
    endtask
    task automatic comp_ready();
        comp_rdy_o = 1'b1;
    endtask
    task automatic set_req(input logic v);
        req_o = v;
    endtask
    // Hold stays released after the warning falls.
    task automatic set_warn(input logic v);
        warn_n_o = v;
    endtask
    task automatic set_core(input logic v);
        core_good_o = v;
    endtask
endmodule // pseq_partner

/* sim/test_projector_power_sequencer.sv */
// Self-checking testbench of the projector power sequencer.
`timescale 1ns/100ps
module test_projector_power_sequencer;
    import pseq_pkg::*;
    localparam int BOOT = 200;
    localparam int PLL = 20;
    localparam int SETUP = 50;
    localparam int PARK = 100;
    localparam int REGS = 50;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hold_n, warn_n, req, comp_rdy, core_good;
    logic [10:0] outs;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    int n;
    int d;
    int t0;
    int seed = 88264;
    initial forever #5 clk_i = ~clk_i;
    pseq_partner u_p (.clk_i(clk_i), .hold_n_o(hold_n), .warn_n_o(warn_n), .req_o(req),
        .comp_rdy_o(comp_rdy), .core_good_o(core_good));
    projector_power_sequencer #(.BOOT_CYCLES(BOOT), .PLL_CYCLES(PLL), .SETUP_CYCLES(SETUP),
        .PARK_CYCLES(PARK), .REG_STOP_CYCLES(REGS)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .power_on_hold_n_i(hold_n),
        .fast_park_warning_n_i(warn_n), .projector_on_request_i(req),
        .companion_ready_i(comp_rdy), .core_power_good_i(core_good),
        .init_busy_o(outs[0]), .init_busy_oe_o(outs[1]), .command_ready_o(outs[2]),
        .pll_lock_req_o(outs[3]), .flash_load_o(outs[4]), .companion_write_o(outs[5]),
        .display_enable_o(outs[6]), .park_active_o(outs[7]), .fast_park_o(outs[8]),
        .reset_reg_enable_o(outs[9]), .low_power_off_o(outs[10]));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task automatic wait_bit(input int i, input logic v, input int lim, output int k);
        k = 0;
        while (outs[i] !== v && k < lim) begin
            @(posedge clk_i);
            #1;
            k++;
        end
    endtask
    function automatic logic in_range(input int k, input int lo, input int hi);
        return k >= lo && k <= hi;
    endfunction
    task automatic summarize();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            summarize();
        end
    end
    initial begin
        repeat (8) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        u_p.step(2);
        check(outs, 0, "outputs after reset");
        for (int t = 0; t < 2; t++) begin
            d = $random(seed) & 255;
            u_p.release_hold(4'($random(seed)));
            wait_bit(0, 1'b1, 4, n);
            check(in_range(n, 1, 2), 1, "busy after release");
            check(outs[1], 1'b1, "busy drive enable");
            check(outs[4:3], 2'b01, "pll before flash");
            t0 = cyc;
            wait_bit(4, 1'b1, PLL + 5, n);
            check(in_range(n, PLL - 1, PLL + 3), 1, "flash after pll");
            u_p.set_req(1'b1);
            u_p.step(d);
            u_p.comp_ready();
            check(outs[6], 1'b0, "request refused during boot");
            wait_bit(5, 1'b1, BOOT + PLL + 20, n);
            check(outs[5], 1'b1, "companion write");
            check(in_range(cyc - t0, BOOT, BOOT + PLL + 300), 1, "boot time");
            wait_bit(2, 1'b1, SETUP + 10, n);
            check(in_range(n, SETUP - 2, SETUP + 5), 1, "setup time");
            check(outs[0], 1'b0, "busy low when done");
            wait_bit(6, 1'b1, 5, n);
            check(outs[6], 1'b1, "display on");
            u_p.step(($random(seed) & 63) + 1);
            u_p.set_req(1'b0);
            wait_bit(7, 1'b1, 4, n);
            check(outs[7:6], 2'b10, "normal park starts");
            wait_bit(7, 1'b0, PARK + 10, n);
            check(in_range(n, 1, PARK + 4), 1, "park duration");
            check(outs[9], 1'b1, "regulation after park");
            wait_bit(9, 1'b0, REGS + 10, n);
            check(in_range(n, REGS - 3, REGS + 4), 1, "regulation stop");
            wait_bit(10, 1'b1, 4, n);
            check(outs[10], 1'b1, "chipset off");
            u_p.set_req(1'b1);
            wait_bit(6, 1'b1, 8, n);
            check(outs[6], 1'b1, "display on again");
            u_p.set_core(1'b0);
            u_p.step(3);
            check(outs[1], 1'b0, "host drive off without core");
            u_p.set_core(1'b1);
            u_p.set_warn(1'b0);
            wait_bit(8, 1'b1, 4, n);
            check(outs[8:6], 3'b100, "fast park starts");
            wait_bit(8, 1'b0, FAST_PARK_CYC + 10, n);
            check(in_range(n, FAST_PARK_CYC - 3, FAST_PARK_CYC + 4), 1, "fast park");
            wait_bit(10, 1'b1, 4, n);
            check(outs[10], 1'b1, "off after fast park");
            u_p.set_req(1'b0);
            u_p.hold_low();
            u_p.step(3);
            check(outs[2:0], 3'b000, "idle while hold low");
            $display("power cycle %0d done", t);
        end
        summarize();
    end
endmodule // test_projector_power_sequencer
